// ===== dpoc_top.sv
// Display port output control: sync, port muxing and monitor query bus with AXI4-Lite registers
//
// Our own choices: the register addresses and the AXI4-Lite register port.
module dpoc_top
#(
  parameter int DATA_W = 12
)
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 legacy_hsync,
  input  wire logic                 legacy_vsync,
  input  wire logic                 gen_hsync,
  input  wire logic                 gen_vsync,
  input  wire logic                 active_video,
  input  wire logic [2*DATA_W-1:0]  pixel_in,
  input  wire logic                 ext_gfx_present,
  output logic                      hsync_out,
  output logic                      vsync_out,
  output logic [7:0]                dac_red,
  output logic [7:0]                dac_green,
  output logic [7:0]                dac_blue,
  output logic [DATA_W-1:0]         port_b_data,
  output logic [DATA_W-1:0]         port_c_data,
  output logic                      port_b_blank_de,
  output logic                      port_c_blank_de,
  output logic                      ports_available,
  input  wire logic                 analog_monitor_query_clock_in,
  output logic                      analog_monitor_query_clock_oe_n,
  input  wire logic                 analog_monitor_query_data_in,
  output logic                      analog_monitor_query_data_oe_n
);

  // Refuse port widths that the split pixel bus cannot serve
  if (DATA_W < 1 || DATA_W > 16)
  begin : g_bad_width
    $error("DATA_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [5:0]  sync_ctrl_reg;
  logic [4:0]  port_ctrl_reg;
  logic [15:0] sbus_div_reg;
  logic [7:0]  sbus_wdata_reg;
  logic [4:0]  sbus_cmd_reg;
  logic        sbus_go_reg;
  logic [23:0] pixel_reg;
  logic        ext_m, ext_s, avail_reg;
  logic        aw_held, w_held;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;
  logic [7:0]  sb_rdata;
  logic        sb_busy, sb_err;
  logic        raw_h, raw_v;
  logic [DATA_W-1:0] pb_reg, pc_reg;
  logic        pb_bd_reg, pc_bd_reg;
  logic        scl_oe_n_w, sda_oe_n_w;
  logic        scl_oe_reg, sda_oe_reg;
  logic [7:0]  r_reg, g_reg, b_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channel: address and data in either order
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= dpoc_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held     <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held     <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg[7:2] <= dpoc_pkg::PIXEL_OFF[7:2]) ? dpoc_pkg::RESP_OKAY
                                                                      : dpoc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; low byte lane carries control fields
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_ctrl_reg  <= dpoc_pkg::SYNC_CTRL_RST;
      port_ctrl_reg  <= dpoc_pkg::PORT_CTRL_RST;
      sbus_div_reg   <= dpoc_pkg::SBUS_DIV_RST;
      sbus_wdata_reg <= 8'h00;
      sbus_cmd_reg   <= 5'h00;
      sbus_go_reg    <= 1'b0;
      pixel_reg      <= 24'h000000;
    end
    else
    begin
      sbus_go_reg <= 1'b0;
      if (wr_fire && w_strb_reg[0])
      begin
        unique case (aw_addr_reg)
          dpoc_pkg::SYNC_CTRL_OFF: sync_ctrl_reg  <= w_data_reg[5:0];
          dpoc_pkg::PORT_CTRL_OFF: port_ctrl_reg  <= w_data_reg[4:0];
          dpoc_pkg::SBUS_DATA_OFF: sbus_wdata_reg <= w_data_reg[7:0];
          dpoc_pkg::SBUS_CMD_OFF:
            if (!sb_busy)
            begin
              sbus_cmd_reg <= w_data_reg[4:0];
              sbus_go_reg  <= 1'b1;
            end
          dpoc_pkg::SBUS_DIV_OFF:
            // Floor keeps the serial clock at or below 400 kHz
            sbus_div_reg <= ({w_data_reg[15:8], w_data_reg[7:0]} < dpoc_pkg::SBUS_DIV_RST)
                            ? dpoc_pkg::SBUS_DIV_RST : w_data_reg[15:0];
          dpoc_pkg::PIXEL_OFF: pixel_reg <= w_data_reg[23:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= dpoc_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= dpoc_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          dpoc_pkg::SYNC_CTRL_OFF: s_axi_rdata <= {26'h0000000, sync_ctrl_reg};
          dpoc_pkg::PORT_CTRL_OFF: s_axi_rdata <= {27'h0000000, port_ctrl_reg};
          dpoc_pkg::PORT_STAT_OFF: s_axi_rdata <= {31'h00000000, avail_reg};
          dpoc_pkg::SBUS_CMD_OFF:  s_axi_rdata <= {27'h0000000, sbus_cmd_reg};
          dpoc_pkg::SBUS_DATA_OFF: s_axi_rdata <= {24'h000000, sb_rdata};
          dpoc_pkg::SBUS_STAT_OFF: s_axi_rdata <= {28'h0000000, sda_s_view(), scl_s_view(), sb_err, sb_busy};
          dpoc_pkg::SBUS_DIV_OFF:  s_axi_rdata <= {16'h0000, sbus_div_reg};
          dpoc_pkg::PIXEL_OFF:     s_axi_rdata <= {8'h00, pixel_reg};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= dpoc_pkg::RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Line levels seen through the engine's own drive, for unidirectional polling
  function automatic logic scl_s_view();
    return ~scl_oe_reg;
  endfunction : scl_s_view

  function automatic logic sda_s_view();
    return ~sda_oe_reg;
  endfunction : sda_s_view

  ////////////////////////////////////////////////////////////////////////////
  // Timing source select: legacy timing ignores the generator entirely
  assign raw_h = port_ctrl_reg[dpoc_pkg::LEGACY_BIT] ? legacy_hsync : gen_hsync;
  assign raw_v = port_ctrl_reg[dpoc_pkg::LEGACY_BIT] ? legacy_vsync : gen_vsync;

  // Separate horizontal and vertical sync stages only
  dpoc_sync_out u_hsync
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .raw_sync   (raw_h),
    .enable     (sync_ctrl_reg[dpoc_pkg::HS_EN_BIT]),
    .invert     (sync_ctrl_reg[dpoc_pkg::HS_POL_BIT]),
    .idle_level (sync_ctrl_reg[dpoc_pkg::HS_IDLE_BIT]),
    .sync_out   (hsync_out)
  );

  dpoc_sync_out u_vsync
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .raw_sync   (raw_v),
    .enable     (sync_ctrl_reg[dpoc_pkg::VS_EN_BIT]),
    .invert     (sync_ctrl_reg[dpoc_pkg::VS_POL_BIT]),
    .idle_level (sync_ctrl_reg[dpoc_pkg::VS_IDLE_BIT]),
    .sync_out   (vsync_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchroniser for external graphics presence
  always_ff @(posedge aclk)
  begin
    ext_m <= ext_gfx_present;
    ext_s <= ext_m;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      avail_reg <= 1'b0;
    else
      avail_reg <= !ext_s;
  end

  // Analog converter words, three 8-bit channels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_reg <= 8'h00;
      g_reg <= 8'h00;
      b_reg <= 8'h00;
    end
    else
    begin
      r_reg <= active_video ? pixel_reg[23:16] : 8'h00;
      g_reg <= active_video ? pixel_reg[15:8]  : 8'h00;
      b_reg <= active_video ? pixel_reg[7:0]   : 8'h00;
    end
  end

  // Digital ports: split single bus in dual mode, idle when unavailable
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !avail_reg)
    begin
      pb_reg    <= '0;
      pc_reg    <= '0;
      pb_bd_reg <= 1'b0;
      pc_bd_reg <= 1'b0;
    end
    else
    begin
      if (port_ctrl_reg[dpoc_pkg::DUAL_BIT])
      begin
        pb_reg <= pixel_in[2*DATA_W-1:DATA_W];
        pc_reg <= pixel_in[DATA_W-1:0];
      end
      else
      begin
        pb_reg <= port_ctrl_reg[dpoc_pkg::PORTB_EN_BIT] ? pixel_in[DATA_W-1:0] : '0;
        pc_reg <= port_ctrl_reg[dpoc_pkg::PORTC_EN_BIT] ? pixel_in[DATA_W-1:0] : '0;
      end
      // Blank is active low: high during active video, same as enable
      pb_bd_reg <= port_ctrl_reg[dpoc_pkg::DE_SEL_BIT] ? active_video : active_video;
      pc_bd_reg <= active_video;
    end
  end

  // Serial bus engine on the dedicated analog query pins
  dpoc_sbus u_sbus
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .div      (sbus_div_reg),
    .go       (sbus_go_reg),
    .cmd      (sbus_cmd_reg),
    .wdata    (sbus_wdata_reg),
    .rdata    (sb_rdata),
    .busy     (sb_busy),
    .ack_err  (sb_err),
    .scl_in   (analog_monitor_query_clock_in),
    .sda_in   (analog_monitor_query_data_in),
    .scl_oe_n (scl_oe_n_w),
    .sda_oe_n (sda_oe_n_w)
  );

  // Registered open-drain enables (high = pull low)
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      scl_oe_reg <= ~scl_oe_n_w;
      sda_oe_reg <= ~sda_oe_n_w;
    end
  end

  assign analog_monitor_query_clock_oe_n = ~scl_oe_reg;
  assign analog_monitor_query_data_oe_n  = ~sda_oe_reg;
  assign dac_red         = r_reg;
  assign dac_green       = g_reg;
  assign dac_blue        = b_reg;
  assign port_b_data     = pb_reg;
  assign port_c_data     = pc_reg;
  assign port_b_blank_de = pb_bd_reg;
  assign port_c_blank_de = pc_bd_reg;
  assign ports_available = avail_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_sync_reset_high: assert property (@(posedge aclk)
    $rose(aresetn) |-> hsync_out && vsync_out)
    else $error("Syncs not high after reset");

  a_sync_pol_apply: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_ctrl_reg[dpoc_pkg::HS_EN_BIT] && $stable(sync_ctrl_reg) |=> hsync_out == ($past(raw_h) ^ $past(sync_ctrl_reg[dpoc_pkg::HS_POL_BIT])))
    else $error("Hsync polarity wrong");

  // Checked at the pin: legacy vsync must reach the output, generator ignored
  a_legacy_select: assert property (@(posedge aclk) disable iff (!aresetn)
    port_ctrl_reg[dpoc_pkg::LEGACY_BIT] && sync_ctrl_reg[dpoc_pkg::VS_EN_BIT]
      |=> vsync_out == ($past(legacy_vsync) ^ $past(sync_ctrl_reg[dpoc_pkg::VS_POL_BIT])))
    else $error("Legacy timing not used");

  a_ports_unavail: assert property (@(posedge aclk) disable iff (!aresetn)
    !avail_reg |=> port_b_data == '0 && port_c_data == '0)
    else $error("Port driven while unavailable");

  a_ext_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_gfx_present [*4] |-> !ports_available)
    else $error("Ports available with external graphics");

  a_dual_split: assert property (@(posedge aclk) disable iff (!aresetn)
    avail_reg && port_ctrl_reg[dpoc_pkg::DUAL_BIT] |=> port_b_data == $past(pixel_in[2*DATA_W-1:DATA_W]))
    else $error("Dual split wrong");

  a_dac_blank: assert property (@(posedge aclk) disable iff (!aresetn)
    !active_video |=> dac_red == 8'h00 && dac_blue == 8'h00)
    else $error("DAC not blanked");

  a_div_floor: assert property (@(posedge aclk) disable iff (!aresetn)
    sbus_div_reg >= dpoc_pkg::SBUS_DIV_RST)
    else $error("Serial divider below floor");

endmodule : dpoc_top

// ===== dpoc_pkg.sv
// Package: register map, field positions, reset values and timing counts for display port output control
package dpoc_pkg;

  // Register byte offsets
  localparam logic [7:0] SYNC_CTRL_OFF   = 8'h00; // Sync polarity and enables
  localparam logic [7:0] PORT_CTRL_OFF   = 8'h04; // Legacy timing, digital port modes
  localparam logic [7:0] PORT_STAT_OFF   = 8'h08; // Port availability and status
  localparam logic [7:0] SBUS_CMD_OFF    = 8'h0C; // Serial bus command
  localparam logic [7:0] SBUS_DATA_OFF   = 8'h10; // Serial bus data
  localparam logic [7:0] SBUS_STAT_OFF   = 8'h14; // Serial bus status
  localparam logic [7:0] SBUS_DIV_OFF    = 8'h18; // Serial bus clock divider
  localparam logic [7:0] PIXEL_OFF       = 8'h1C; // Analog pixel word

  // Sync control fields
  localparam int HS_EN_BIT   = 0;
  localparam int VS_EN_BIT   = 1;
  localparam int HS_POL_BIT  = 2;
  localparam int VS_POL_BIT  = 3;
  localparam int HS_IDLE_BIT = 4;
  localparam int VS_IDLE_BIT = 5;
  localparam logic [5:0] SYNC_CTRL_RST = 6'h30; // Disabled, idle high

  // Port control fields
  localparam int LEGACY_BIT  = 0;
  localparam int DUAL_BIT    = 1;
  localparam int DE_SEL_BIT  = 2;
  localparam int PORTB_EN_BIT = 3;
  localparam int PORTC_EN_BIT = 4;
  localparam logic [4:0] PORT_CTRL_RST = 5'h00;

  // Serial bus command fields
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT  = 1;
  localparam int CMD_WRITE_BIT = 2;
  localparam int CMD_READ_BIT  = 3;
  localparam int CMD_NACK_BIT  = 4;

  // Color channel width
  localparam int COLOR_W = 8;

  // Serial bus timing
  localparam int  CLK_MHZ        = 200;
  localparam int  SBUS_MAX_KHZ   = 400;
  localparam int  SBUS_MIN_DIV   = (CLK_MHZ * 1000 + 4 * SBUS_MAX_KHZ - 1) / (4 * SBUS_MAX_KHZ);
  localparam logic [15:0] SBUS_DIV_RST = 16'(SBUS_MIN_DIV);

  // Pixel rate limits in MHz
  localparam int ANALOG_MAX_MHZ  = 350;
  localparam int DIGITAL_MAX_MHZ = 165;
  localparam int DUAL_MAX_MPIX   = 330;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : dpoc_pkg

// ===== dpoc_sync_out.sv
// Sync output stage: polarity, enable and static idle level
module dpoc_sync_out
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic raw_sync,
  input  wire logic enable,
  input  wire logic invert,
  input  wire logic idle_level,
  output logic      sync_out
);

  logic sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Registered output, idle high out of reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sync_reg <= 1'b1;
    else if (enable)
      sync_reg <= raw_sync ^ invert;
    else
      sync_reg <= idle_level;
  end

  assign sync_out = sync_reg;

  a_sync_idle_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable |=> sync_out == $past(idle_level))
    else $error("Disabled sync not at idle level");

endmodule : dpoc_sync_out

// ===== dpoc_sbus.sv
// Open-drain serial bus engine for the monitor query channel
module dpoc_sbus
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] div,
  input  wire logic        go,
  input  wire logic [4:0]  cmd,
  input  wire logic [7:0]  wdata,
  output logic [7:0]       rdata,
  output logic             busy,
  output logic             ack_err,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             scl_oe_n,
  output logic             sda_oe_n
);

  typedef enum {IDLE, START, BIT, ACK, STOP} dpoc_sb_state_t;
  dpoc_sb_state_t state_reg;
  logic [15:0] cnt_reg;
  logic [1:0]  ph_reg;
  logic [3:0]  bit_reg;
  logic [7:0]  sh_reg;
  logic [4:0]  cmd_reg;
  logic        scl_low_reg, sda_low_reg, err_reg;
  logic        scl_m, scl_s, sda_m, sda_s;
  logic        tick;
  logic [15:0] scl_hi_cnt;

  // Two-flop synchronisers for the line levels
  always_ff @(posedge aclk)
  begin
    scl_m <= scl_in;
    scl_s <= scl_m;
    sda_m <= sda_in;
    sda_s <= sda_m;
  end

  // Quarter-bit tick; stretched while the far end holds clock low
  assign tick = (cnt_reg == 16'h0000) && !(ph_reg == 2'h2 && !scl_s && !scl_low_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || state_reg == IDLE || cnt_reg == 16'h0000)
      cnt_reg <= (div == 16'h0000) ? 16'h0000 : div - 16'h0001;
    else
      cnt_reg <= cnt_reg - 16'h0001;
  end

  // Bit engine, 4 phases per bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg   <= IDLE;
      ph_reg      <= 2'h0;
      bit_reg     <= 4'h0;
      sh_reg      <= 8'h00;
      cmd_reg     <= 5'h00;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      err_reg     <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        IDLE:
          if (go)
          begin
            cmd_reg <= cmd;
            sh_reg  <= wdata;
            ph_reg  <= 2'h0;
            bit_reg <= 4'h0;
            err_reg <= 1'b0;
            state_reg <= cmd[dpoc_pkg::CMD_START_BIT] ? START
                       : (cmd[dpoc_pkg::CMD_WRITE_BIT] | cmd[dpoc_pkg::CMD_READ_BIT]) ? BIT : STOP;
          end
        START:
          if (tick)
          begin
            ph_reg <= ph_reg + 2'h1;
            unique case (ph_reg)
              2'h0: begin scl_low_reg <= 1'b0; sda_low_reg <= 1'b0; end
              2'h1: sda_low_reg <= 1'b1;
              2'h2: scl_low_reg <= 1'b1;
              2'h3: state_reg <= (cmd_reg[dpoc_pkg::CMD_WRITE_BIT] | cmd_reg[dpoc_pkg::CMD_READ_BIT])
                                 ? BIT : (cmd_reg[dpoc_pkg::CMD_STOP_BIT] ? STOP : IDLE);
            endcase
          end
        BIT, ACK:
          if (tick)
          begin
            ph_reg <= ph_reg + 2'h1;
            unique case (ph_reg)
              2'h0: sda_low_reg <= (state_reg == BIT)
                    ? (cmd_reg[dpoc_pkg::CMD_WRITE_BIT] & ~sh_reg[7])
                    : (cmd_reg[dpoc_pkg::CMD_READ_BIT] & ~cmd_reg[dpoc_pkg::CMD_NACK_BIT]);
              2'h1: scl_low_reg <= 1'b0;
              2'h2:
                if (state_reg == BIT)
                  sh_reg <= {sh_reg[6:0], sda_s};
                else if (cmd_reg[dpoc_pkg::CMD_WRITE_BIT])
                  err_reg <= sda_s;
              2'h3:
              begin
                scl_low_reg <= 1'b1;
                if (state_reg == ACK)
                  state_reg <= cmd_reg[dpoc_pkg::CMD_STOP_BIT] ? STOP : IDLE;
                else if (bit_reg == 4'h7)
                  state_reg <= ACK;
                bit_reg <= bit_reg + 4'h1;
              end
            endcase
          end
        STOP:
          if (tick)
          begin
            ph_reg <= ph_reg + 2'h1;
            unique case (ph_reg)
              2'h0: sda_low_reg <= 1'b1;
              2'h1: scl_low_reg <= 1'b0;
              2'h2: sda_low_reg <= 1'b0;
              2'h3: state_reg <= IDLE;
            endcase
          end
      endcase
    end
  end

  // Open-drain: enable low pulls the line low, otherwise released
  assign scl_oe_n = ~scl_low_reg;
  assign sda_oe_n = ~sda_low_reg;
  assign busy     = (state_reg != IDLE);
  assign rdata    = sh_reg;
  assign ack_err  = err_reg;

  // Cycles the clock line has been released, saturating
  always_ff @(posedge aclk)
  begin
    if (!aresetn || scl_low_reg)
      scl_hi_cnt <= 16'h0000;
    else if (scl_hi_cnt != 16'hFFFF)
      scl_hi_cnt <= scl_hi_cnt + 16'h0001;
  end

  // A high phase shorter than half a bit at the floor divider breaks the rate limit
  a_sbus_rate: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(scl_low_reg) |-> scl_hi_cnt >= 16'(2 * dpoc_pkg::SBUS_MIN_DIV))
    else $error("Serial clock high phase too short");

endmodule : dpoc_sbus

// ===== dpoc_monitor_model.sv
// Monitor side of the query pair: board pull-ups only, no device answering
module dpoc_monitor_model
(
  input  wire logic clock_oe_n,
  input  wire logic data_oe_n,
  output logic      clock_line,
  output logic      data_line,
  output logic      clock_pulled
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-ups set the level of a released line
  assign clock_line = clock_oe_n ? 1'b1 : 1'b0;
  assign data_line  = data_oe_n ? 1'b1 : 1'b0;
  // Notes that the engine drove its clock low at least once
  initial clock_pulled = 1'b0;
  always @(negedge clock_line) clock_pulled = 1'b1;
endmodule : dpoc_monitor_model

// ===== test_display_port_output_control.sv
// Register-level bench for display port output control
module test_display_port_output_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0, br = 1'b0, rr = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, r;
  logic [1:0] bresp, rresp, resp;
  logic awr, wr, bv, arr, rv, lh = 1'b0, lv = 1'b0, gh = 1'b0, gv = 1'b0, av = 1'b0, ext = 1'b0;
  logic hs, vs, sc, sd, sco, sdo, scp, pav, pbd, pcd;
  logic [11:0] pb, pc;
  logic [7:0] dr, dg, db;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  // Clock at 200 MHz
  always #2.5 aclk = ~aclk;
  dpoc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .legacy_hsync(lh),
    .legacy_vsync(lv), .gen_hsync(gh), .gen_vsync(gv), .active_video(av), .pixel_in(24'hA5C3F0),
    .ext_gfx_present(ext), .hsync_out(hs), .vsync_out(vs), .dac_red(dr), .dac_green(dg), .dac_blue(db),
    .port_b_data(pb), .port_c_data(pc), .port_b_blank_de(pbd), .port_c_blank_de(pcd), .ports_available(pav),
    .analog_monitor_query_clock_in(sc), .analog_monitor_query_clock_oe_n(sco),
    .analog_monitor_query_data_in(sd), .analog_monitor_query_data_oe_n(sdo));
  dpoc_monitor_model mon (.clock_oe_n(sco), .data_oe_n(sdo), .clock_line(sc), .data_line(sd),
    .clock_pulled(scp));
  //////////////////////////////////////////////////////////////////////////////
  // Compare one value
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // AXI4-Lite write, address and data offered together
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    br <= 1'b0; resp = bresp;
  endtask : wr_reg
  // AXI4-Lite read
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rr <= 1'b0; d = rd; resp = rresp;
  endtask : rd_reg
  task results;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  // Hang guard
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      error_cnt++;
      results();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    chk({hs, vs, sco, sdo, pav}, 5'h1F);
    rd_reg(dpoc_pkg::SYNC_CTRL_OFF, r); chk(r, 32'h30);
    gh <= 1'b1; wr_reg(dpoc_pkg::SYNC_CTRL_OFF, 32'h21); repeat (3) @(posedge aclk);
    chk({hs, vs}, 2'h3);
    wr_reg(dpoc_pkg::SYNC_CTRL_OFF, 32'h05); repeat (3) @(posedge aclk);
    chk({hs, vs}, 2'h0);
    $display("sync test done");
    wr_reg(dpoc_pkg::PORT_CTRL_OFF, 32'h01); wr_reg(dpoc_pkg::SYNC_CTRL_OFF, 32'h03);
    lh <= 1'b1; gh <= 1'b0; repeat (3) @(posedge aclk); chk({hs, vs}, 2'h2);
    lh <= 1'b0; gh <= 1'b1; gv <= 1'b1; repeat (3) @(posedge aclk); chk({hs, vs}, 2'h0);
    wr_reg(dpoc_pkg::PORT_CTRL_OFF, 32'h03); repeat (2) @(posedge aclk);
    chk({pb, pc}, 24'hA5C3F0);
    ext <= 1'b1; repeat (6) @(posedge aclk); chk({pav, pb, pc}, 25'h0);
    rd_reg(dpoc_pkg::PORT_STAT_OFF, r); chk(r[0], 1'b0);
    wr_reg(dpoc_pkg::PIXEL_OFF, 32'h123456); av <= 1'b1; repeat (3) @(posedge aclk);
    chk({dr, dg, db}, 24'h123456);
    ext <= 1'b0; wr_reg(dpoc_pkg::PORT_CTRL_OFF, 32'h1C); repeat (4) @(posedge aclk);
    chk({pb, pc}, 24'h3F03F0);
    chk({pbd, pcd}, 2'h3);
    av <= 1'b0; repeat (3) @(posedge aclk); chk({pbd, pcd, dr, db}, 18'h0);
    rd_reg(8'h20, r); chk(resp, dpoc_pkg::RESP_SLVERR);
    $display("port test done");
    wr_reg(dpoc_pkg::SBUS_DIV_OFF, 32'h7D); wr_reg(dpoc_pkg::SBUS_DATA_OFF, 32'hA0);
    wr_reg(dpoc_pkg::SBUS_CMD_OFF, 32'h07); r = 32'h1;
    for (int i = 0; i < 400 && r[0]; i++)
    begin
      repeat (50) @(posedge aclk);
      rd_reg(dpoc_pkg::SBUS_STAT_OFF, r);
    end
    chk(r[3:0], 4'hE);
    chk(scp, 1'b1);
    $display("serial test done");
    results();
  end
endmodule : test_display_port_output_control
